// *** verilog/ctf_crit_flags.sv ***
/*
  Critical-temperature status flags: three alarm levels times three channels
  (local, remote a, remote b), hysteresis comparators, mask gating, active-low
  alarm outputs, summary flags and the read port of the three flag registers.
  Assumes readings, limits, hysteresis and masks come from same-clock logic
  (conversion engine and register file) and that the command decoder of the
  serial interface presents a command code with a read strobe.
*/
// Functional notes
// - Unmasked set flag activates its alarm output
// - Alarm deactivates when all its flags clear
// - Local flag sets at reading >= limit
// - Local flag clears below limit minus hysteresis
// - Remote a flag sets at reading >= limit
// - Remote a clears below limit minus hysteresis
// - Remote b flag sets at reading >= limit
// - Remote b clears below limit minus hysteresis
// - First flag register at 0x08, b2..b0
// - Second flag register at 0x09, b2..b0
// - Third flag register at 0x0a, b2..b0
// - Bits 7 to 3 read zero
// - Mask bit one blocks event from alarm
// - Summary flag follows any bit set
module ctf_crit_flags
  import ctf_pkg::*;
#(
  parameter int TEMP_W = CTF_TEMP_W
) (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // Readings of local, remote a, remote b (unsigned codes)
  input wire logic [TEMP_W-1:0] temp_local_in,
  input wire logic [TEMP_W-1:0] temp_remote_a_in,
  input wire logic [TEMP_W-1:0] temp_remote_b_in,
  // Limits, packed per level as {remote_b, remote_a, local}
  input wire logic [3*TEMP_W-1:0] limit_first_in,
  input wire logic [3*TEMP_W-1:0] limit_second_in,
  input wire logic [3*TEMP_W-1:0] limit_third_in,
  input wire logic [TEMP_W-1:0] hysteresis_in,
  // Masks per level, bit order as the flag registers
  input wire logic [2:0] mask_first_in,
  input wire logic [2:0] mask_second_in,
  input wire logic [2:0] mask_third_in,
  // Register read port
  input wire logic rd_en_in,
  input wire logic [7:0] rd_cmd_in,
  output logic [7:0] rd_data_out,
  output logic rd_hit_out,
  // Alarm pins, active low
  output logic alarm_out_first_n_out,
  output logic alarm_out_second_n_out,
  output logic alarm_out_third_n_out,
  // Summary flags for the common status register
  output logic summary_flag_first_out,
  output logic summary_flag_second_out,
  output logic summary_flag_third_out
);

  // Elaboration check: the comparators are built for 2 to 16 bit readings
  if (TEMP_W < 2 || TEMP_W > 16) begin : g_bad_width
    $error("ctf_crit_flags: TEMP_W must be 2 to 16");
  end

  // Readings and limits gathered for indexing by level and channel
  wire [TEMP_W-1:0] temp_w [CTF_NUM_CHAN];
  wire [3*TEMP_W-1:0] limit_w [CTF_NUM_LEVEL];
  wire [2:0] mask_w [CTF_NUM_LEVEL];
  assign temp_w[CTF_BIT_LOCAL] = temp_local_in;
  assign temp_w[CTF_BIT_REMOTE_A] = temp_remote_a_in;
  assign temp_w[CTF_BIT_REMOTE_B] = temp_remote_b_in;
  assign limit_w[0] = limit_first_in;
  assign limit_w[1] = limit_second_in;
  assign limit_w[2] = limit_third_in;
  assign mask_w[0] = mask_first_in;
  assign mask_w[1] = mask_second_in;
  assign mask_w[2] = mask_third_in;

  logic [2:0] flags_q [CTF_NUM_LEVEL];
  logic [2:0] flags_d [CTF_NUM_LEVEL];
  logic [CTF_NUM_LEVEL-1:0] alarm_n_q;
  logic [CTF_NUM_LEVEL-1:0] summary_q;
  wire [CTF_NUM_LEVEL-1:0] alarm_hit_w;
  wire [CTF_NUM_LEVEL-1:0] any_w;

  genvar lv, ch;
  generate
    for (lv = 0; lv < CTF_NUM_LEVEL; lv++) begin : g_level
      for (ch = 0; ch < CTF_NUM_CHAN; ch++) begin : g_chan
        wire [TEMP_W-1:0] lim_w;
        wire [TEMP_W:0] release_w;
        wire set_w;
        wire clr_w;
        assign lim_w = limit_w[lv][ch*TEMP_W +: TEMP_W];
        // Compare with one spare bit so a hysteresis above the limit does not wrap
        assign release_w = {1'b0, lim_w} - {1'b0, hysteresis_in};
        assign set_w = temp_w[ch] >= lim_w;
        // Release point below zero means the flag can never clear
        assign clr_w = !release_w[TEMP_W] &&
                       ({1'b0, temp_w[ch]} < release_w);
        // Set has priority; between the thresholds the flag holds
        assign flags_d[lv][ch] = set_w ? 1'b1 :
                                 (clr_w ? 1'b0 : flags_q[lv][ch]);
      end
      // Mask bit one blocks the channel from the pin
      assign alarm_hit_w[lv] = |(flags_q[lv] & ~mask_w[lv]);
      assign any_w[lv] = |flags_q[lv];
    end
  endgenerate

  // Comparator flags; one register stage per level
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < CTF_NUM_LEVEL; i++) begin
        flags_q[i] <= CTF_FLAGS_RESET;
      end
    end else if (clk_en_in) begin
      for (int i = 0; i < CTF_NUM_LEVEL; i++) begin
        flags_q[i] <= flags_d[i];
      end
    end
  end

  // Alarm pins and summary flags follow the registered flags one cycle later
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      alarm_n_q <= {CTF_NUM_LEVEL{CTF_ALARM_N_RESET}};
      summary_q <= '0;
    end else if (clk_en_in) begin
      alarm_n_q <= ~alarm_hit_w;
      summary_q <= any_w;
    end
  end

  assign alarm_out_first_n_out = alarm_n_q[0];
  assign alarm_out_second_n_out = alarm_n_q[1];
  assign alarm_out_third_n_out = alarm_n_q[2];
  assign summary_flag_first_out = summary_q[0];
  assign summary_flag_second_out = summary_q[1];
  assign summary_flag_third_out = summary_q[2];

  // Read decode; unknown codes return zero with no hit so other blocks may answer
  wire sel_first_w = rd_cmd_in == CTF_CMD_LEVEL1;
  wire sel_second_w = rd_cmd_in == CTF_CMD_LEVEL2;
  wire sel_third_w = rd_cmd_in == CTF_CMD_LEVEL3;
  wire [2:0] rd_sel_w = sel_first_w ? flags_q[0] :
                        sel_second_w ? flags_q[1] :
                        sel_third_w ? flags_q[2] : 3'h0;
  wire rd_match_w = sel_first_w | sel_second_w | sel_third_w;
  logic [7:0] rd_data_q;
  logic rd_hit_q;

  // Read data registered one cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_q <= CTF_RDATA_RESET;
      rd_hit_q <= 1'b0;
    end else if (clk_en_in) begin
      rd_data_q <= rd_en_in ? {5'h00, rd_sel_w} : CTF_RDATA_RESET;
      rd_hit_q <= rd_en_in & rd_match_w;
    end
  end

  assign rd_data_out = rd_data_q;
  assign rd_hit_out = rd_hit_q;

  // Checks
  a_flag_sets: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && temp_local_in >= limit_first_in[TEMP_W-1:0]
    |=> flags_q[0][CTF_BIT_LOCAL])
    else $error("local first flag did not set");
  a_remote_a_set: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && temp_remote_a_in >= limit_second_in[2*TEMP_W-1:TEMP_W]
    |=> flags_q[1][CTF_BIT_REMOTE_A])
    else $error("remote a second flag did not set");
  a_remote_b_set: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && temp_remote_b_in >= limit_third_in[3*TEMP_W-1:2*TEMP_W]
    |=> flags_q[2][CTF_BIT_REMOTE_B])
    else $error("remote b third flag did not set");
  a_band_holds: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && !g_level[0].g_chan[0].set_w && !g_level[0].g_chan[0].clr_w
    |=> flags_q[0][0] == $past(flags_q[0][0]))
    else $error("flag changed inside hysteresis band");
  a_flag_clears: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && g_level[1].g_chan[2].clr_w && !g_level[1].g_chan[2].set_w
    |=> !flags_q[1][2])
    else $error("flag did not clear below release point");
  a_no_early_clear: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    $fell(flags_q[2][1]) |-> $past(g_level[2].g_chan[1].clr_w))
    else $error("flag cleared without falling below release point");
  a_alarm_follows: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in |=> alarm_out_first_n_out == !(|($past(flags_q[0]) & ~$past(mask_first_in))))
    else $error("first alarm pin disagrees with flags and mask");
  a_alarm_idle: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && flags_q[1] == 3'h0 |=> alarm_out_second_n_out)
    else $error("second alarm active with no flags");
  a_summary_any: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in |=> summary_flag_third_out == |$past(flags_q[2]))
    else $error("third summary flag wrong");
  a_read_zero: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    rd_data_out[7:3] == 5'h00)
    else $error("reserved read bits not zero");
  a_read_second: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && rd_en_in && rd_cmd_in == CTF_CMD_LEVEL2
    |=> rd_hit_out && rd_data_out[2:0] == $past(flags_q[1]))
    else $error("second flag register read wrong");

  // Set checks for the remaining level and channel pairs
  a_local_second_set: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && temp_local_in >= limit_second_in[TEMP_W-1:0]
    |=> flags_q[1][CTF_BIT_LOCAL])
    else $error("local second flag did not set");
  a_local_third_set: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && temp_local_in >= limit_third_in[TEMP_W-1:0]
    |=> flags_q[2][CTF_BIT_LOCAL])
    else $error("local third flag did not set");
  a_remote_a_first: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && temp_remote_a_in >= limit_first_in[2*TEMP_W-1:TEMP_W]
    |=> flags_q[0][CTF_BIT_REMOTE_A])
    else $error("remote a first flag did not set");
  a_remote_a_third: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && temp_remote_a_in >= limit_third_in[2*TEMP_W-1:TEMP_W]
    |=> flags_q[2][CTF_BIT_REMOTE_A])
    else $error("remote a third flag did not set");
  a_remote_b_first: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && temp_remote_b_in >= limit_first_in[3*TEMP_W-1:2*TEMP_W]
    |=> flags_q[0][CTF_BIT_REMOTE_B])
    else $error("remote b first flag did not set");
  a_remote_b_second: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && temp_remote_b_in >= limit_second_in[3*TEMP_W-1:2*TEMP_W]
    |=> flags_q[1][CTF_BIT_REMOTE_B])
    else $error("remote b second flag did not set");

  // Clear checks below the release point
  a_local_clears: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && g_level[0].g_chan[0].clr_w && !g_level[0].g_chan[0].set_w
    |=> !flags_q[0][0])
    else $error("local first flag did not clear");
  a_remote_a_clears: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && g_level[0].g_chan[1].clr_w && !g_level[0].g_chan[1].set_w
    |=> !flags_q[0][1])
    else $error("remote a first flag did not clear");

  // Enable low must freeze every stage, pins included
  a_freeze_flags: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !clk_en_in |=> flags_q[0] == $past(flags_q[0]) && flags_q[1] == $past(flags_q[1])
    && flags_q[2] == $past(flags_q[2]))
    else $error("flags moved while enable low");
  a_freeze_pins: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !clk_en_in |=> $stable(alarm_n_q) && $stable(summary_q))
    else $error("alarm or summary moved while enable low");

  // Pins of the other levels and the summary of the first level
  a_alarm_second: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in |=> alarm_out_second_n_out == !(|($past(flags_q[1]) & ~$past(mask_second_in))))
    else $error("second alarm pin disagrees with flags and mask");
  a_alarm_third: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in |=> alarm_out_third_n_out == !(|($past(flags_q[2]) & ~$past(mask_third_in))))
    else $error("third alarm pin disagrees with flags and mask");
  a_alarm_idle_third: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && flags_q[2] == 3'h0 |=> alarm_out_third_n_out)
    else $error("third alarm active with no flags");
  a_summary_first: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in |=> summary_flag_first_out == |$past(flags_q[0]))
    else $error("first summary flag wrong");

  // Read port: each register, unknown codes and idle cycles
  a_read_first: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && rd_en_in && rd_cmd_in == CTF_CMD_LEVEL1
    |=> rd_hit_out && rd_data_out[2:0] == $past(flags_q[0]))
    else $error("first flag register read wrong");
  a_read_third: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && rd_en_in && rd_cmd_in == CTF_CMD_LEVEL3
    |=> rd_hit_out && rd_data_out[2:0] == $past(flags_q[2]))
    else $error("third flag register read wrong");
  a_read_unknown: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && rd_en_in && !rd_match_w
    |=> !rd_hit_out && rd_data_out == 8'h00)
    else $error("unknown code answered");
  a_read_idle: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clk_en_in && !rd_en_in |=> !rd_hit_out && rd_data_out == 8'h00)
    else $error("read port not idle without strobe");

  // Main scenarios; the bench reaches all but c_alarm_off, as it never raises the third alarm pin
  c_frozen: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !clk_en_in && summary_q != 3'h0);
  c_alarm_on: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    $fell(alarm_out_first_n_out));
  c_alarm_off: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    $rose(alarm_out_third_n_out));
  c_masked: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    flags_q[0] != 3'h0 && alarm_out_first_n_out);
  c_read_hit: cover property (@(posedge ref_clk_in) disable iff (!resetn_in)
    rd_hit_out && rd_data_out != 8'h00);

endmodule : ctf_crit_flags

// *** verilog/ctf_pkg.sv ***
/*
  Package for the critical-temperature status flag block: command codes of the
  flag registers, field positions, reset values and widths.
  Assumes a single 250 MHz clock domain and an 8-bit register read path.
*/
package ctf_pkg;
  // Command codes of the read-only flag registers
  localparam logic [7:0] CTF_CMD_LEVEL1 = 8'h08;
  localparam logic [7:0] CTF_CMD_LEVEL2 = 8'h09;
  localparam logic [7:0] CTF_CMD_LEVEL3 = 8'h0a;
  // Flag positions inside each register
  localparam int CTF_BIT_LOCAL = 0;
  localparam int CTF_BIT_REMOTE_A = 1;
  localparam int CTF_BIT_REMOTE_B = 2;
  // Counts and widths
  localparam int CTF_NUM_CHAN = 3;
  localparam int CTF_NUM_LEVEL = 3;
  localparam int CTF_TEMP_W = 8;
  // Values after reset
  localparam logic [2:0] CTF_FLAGS_RESET = 3'h0;
  localparam logic [7:0] CTF_RDATA_RESET = 8'h00;
  localparam logic CTF_ALARM_N_RESET = 1'b1;
endpackage : ctf_pkg

// *** verif/ctf_host_model.sv ***
/*
  Host side of the flag register read port: issues one-byte reads by command code.
  Assumes the bench calls rd hierarchically and that inputs change at falling edges.
*/
module ctf_host_model (
  // Clock
  input wire logic clk_in,
  // Read port of the block
  input wire logic [7:0] rd_data_in,
  input wire logic rd_hit_in,
  output logic rd_en_out,
  output logic [7:0] rd_cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: strobe low, command holds 8'ha5 or the inverse of the last code so stale codes never look valid
  initial begin
    rd_en_out = 1'b0;
    rd_cmd_out = 8'ha5;
  end
  // One read: strobe for a single edge; the answer stands for one cycle only,
  // so it is taken at the next falling edge, before the strobe drops
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data, output logic hit);
    @(negedge clk_in);
    rd_en_out = 1'b1;
    rd_cmd_out = cmd;
    @(negedge clk_in);
    data = rd_data_in;
    hit = rd_hit_in;
    rd_en_out = 1'b0;
    rd_cmd_out = ~cmd;
  endtask : rd
endmodule : ctf_host_model

// *** verif/ctf_crit_flags_tb_top.sv ***
/*
  Self-checking bench of the critical flag block: reset state, hysteresis band per
  channel, masks and the three alarm levels. Assumes the host model above.
*/
module ctf_crit_flags_tb_top
  import ctf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] t_l = 8'h00, t_a = 8'h00, t_b = 8'h00, hyst = 8'h05;
  logic [23:0] lim1 = 24'h505050, lim2 = 24'h606060, lim3 = 24'h707070;
  logic [2:0] m1 = 3'h0, m2 = 3'h0, m3 = 3'h0;
  logic en = 1'b1;
  logic rd_en, rd_hit, al1, al2, al3, s1, s2, s3;
  logic [7:0] rd_cmd, rd_data;
  int mismatches = 0;
  int n_compared = 0;
  ctf_crit_flags dut_u (.ref_clk_in(clk), .resetn_in(rst_n), .clk_en_in(en),
    .temp_local_in(t_l), .temp_remote_a_in(t_a), .temp_remote_b_in(t_b),
    .limit_first_in(lim1), .limit_second_in(lim2), .limit_third_in(lim3),
    .hysteresis_in(hyst), .mask_first_in(m1), .mask_second_in(m2), .mask_third_in(m3),
    .rd_en_in(rd_en), .rd_cmd_in(rd_cmd), .rd_data_out(rd_data), .rd_hit_out(rd_hit),
    .alarm_out_first_n_out(al1), .alarm_out_second_n_out(al2),
    .alarm_out_third_n_out(al3), .summary_flag_first_out(s1),
    .summary_flag_second_out(s2), .summary_flag_third_out(s3));
  ctf_host_model host_u (.clk_in(clk), .rd_data_in(rd_data), .rd_hit_in(rd_hit),
    .rd_en_out(rd_en), .rd_cmd_out(rd_cmd));
  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic complete_run;
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Read a register; hit is expected only for the three flag codes
  task automatic rdchk(input logic [7:0] cmd, input logic [7:0] e);
    logic [7:0] d;
    logic h;
    host_u.rd(cmd, d, h);
    chk("rd_data", e, d);
    chk("rd_hit", {7'h0, cmd inside {CTF_CMD_LEVEL1, CTF_CMD_LEVEL2, CTF_CMD_LEVEL3}}, {7'h0, h});
  endtask : rdchk
  // Flag needs one edge, pins one more, so two edges pass before checking
  task automatic set_t(input logic [7:0] l, input logic [7:0] a, input logic [7:0] b);
    @(negedge clk);
    t_l = l;
    t_a = a;
    t_b = b;
    repeat (2) @(negedge clk);
  endtask : set_t
  task automatic reset_values;
    chk("alarms", 8'h07, {5'h0, al3, al2, al1});
    chk("summaries", 8'h00, {5'h0, s3, s2, s1});
    rdchk(8'h0b, 8'h00);
  endtask : reset_values
  // Walk each channel just under the limit, on it, at the band edge and below it
  task automatic band_walk;
    logic [7:0] v[4] = '{8'h4f, 8'h50, 8'h4b, 8'h4a};
    logic f[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 4; i++) begin
        set_t(c == 0 ? v[i] : 8'h00, c == 1 ? v[i] : 8'h00, c == 2 ? v[i] : 8'h00);
        rdchk(CTF_CMD_LEVEL1, {5'h0, 3'(f[i]) << c});
        chk("alarm_first", {7'h0, !f[i]}, {7'h0, al1});
        chk("summary_first", {7'h0, f[i]}, {7'h0, s1});
      end
    end
  endtask : band_walk
  // Flags differ at the third level only; masks hide events from pins but not from registers
  task automatic masks_levels;
    @(negedge clk);
    m1 = 3'h5;
    m3 = 3'h7;
    set_t(8'h70, 8'h65, 8'hff);
    rdchk(CTF_CMD_LEVEL1, 8'h07);
    rdchk(CTF_CMD_LEVEL2, 8'h07);
    rdchk(CTF_CMD_LEVEL3, 8'h05);
    chk("alarms", 8'h04, {5'h0, al3, al2, al1});
    chk("summaries", 8'h07, {5'h0, s3, s2, s1});
    @(negedge clk);
    m1 = 3'h7;
    repeat (2) @(negedge clk);
    chk("alarms", 8'h05, {5'h0, al3, al2, al1});
  endtask : masks_levels
  // Enable low freezes flags and pins although readings drop; they move once it returns
  task automatic freeze_check;
    @(negedge clk);
    en = 1'b0;
    t_l = 8'h00;
    t_a = 8'h00;
    t_b = 8'h00;
    repeat (3) @(negedge clk);
    chk("frozen_summaries", 8'h07, {5'h0, s3, s2, s1});
    chk("frozen_alarms", 8'h05, {5'h0, al3, al2, al1});
    en = 1'b1;
    repeat (2) @(negedge clk);
    chk("summaries", 8'h00, {5'h0, s3, s2, s1});
    chk("alarms", 8'h07, {5'h0, al3, al2, al1});
  endtask : freeze_check
  // Main sequence with a bounded watchdog beside it
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    reset_values();
    band_walk();
    masks_levels();
    freeze_check();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule : ctf_crit_flags_tb_top
